// ===== src/pio_port.sv
/*
 * Parallel I/O port with pin control, reached over AXI4-Lite.
 * Assumes peripherals present their pin requests synchronously to aclk and
 * that low-power modes only gate activity, never the register state.
 */
// How it works
// [R1] A shared peripheral function overrides the port function on its pin.
// [R2] Enabling a peripheral removes port control from every pin it shares.
// [R3] After reset no peripheral function is enabled; the port owns all pins except the output-only pin, which debug mode holds.
// [R4] Reset makes all pins inputs, pulls off; output-only pin starts in debug mode.
// [R5] Reset selects low drive strength on every pin.
// [R6] Direction bit enables the output buffer and selects the read source; the output-only pin's direction bit is held at 0, so the port never drives it.
// [R7] Direction 0 reads the pin level; direction 1 drives and reads the latch.
// [R8] Data writes latch all bits; output bits drive their latched level.
// [R9] Reset clears the data latch; nothing is driven since pins are inputs.
// [R10] Input buffer is on unless the pin is analog or output-only.
// [R11] A digital function drives the pad; direction still selects read source.
// [R12] An analog function disables both input and output buffers.
// [R13] An input bit with its input buffer off reads as zero.
// [R14] Analog beats digital when both are enabled on one pin.
// [R15] Software should write data before turning a pin into an output.
// [R16] Pull and slew settings act independently of data and direction.
// [R17] In wait and stop every pin state is held; low_power freezes only peripheral requests, not bdm_release or writes.
// [R18] After low power every pin function is as before stop.
// [R19] Registers update on aclk writes and reset on the system reset.
`timescale 1ns/1ps
module pio_port (
    input  logic                 aclk,
    input  logic                 aresetn,
    input  logic [7:0]           s_axi_awaddr,
    input  logic                 s_axi_awvalid,
    output logic                 s_axi_awready,
    input  logic [31:0]          s_axi_wdata,
    input  logic [3:0]           s_axi_wstrb,
    input  logic                 s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  logic                 s_axi_bready,
    input  logic [7:0]           s_axi_araddr,
    input  logic                 s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  logic                 s_axi_rready,
    input  pio_pkg::pio_periph_s periph,
    input  logic                 bdm_release,
    input  logic                 low_power,
    input  logic [7:0]           pin_in,
    output pio_pkg::pio_pad_s    pad
);
    import pio_pkg::*;

    typedef struct packed {
        pio_cfg_s    cfg;
        logic        bdm_en;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        pio_periph_s periph;
    } pio_state_s;

    pio_state_s st_q;
    pio_state_s st_d;
    logic [7:0] rd_port;
    pio_pad_s   pad_c;

    function automatic logic pio_mapped(input logic [7:0] a);
        return a == PIO_OFS_DATA || a == PIO_OFS_DIR || a == PIO_OFS_PULL ||
               a == PIO_OFS_SLEW || a == PIO_OFS_DRIVE || a == PIO_OFS_PINLVL ||
               a == PIO_OFS_ID;
    endfunction

    pio_pin_cell u_cell (
        .cfg     (st_q.cfg),
        .periph  (st_q.periph),
        .pin_in  (pin_in),
        .bdm_en  (st_q.bdm_en),
        .pad     (pad_c),
        .rd_data (rd_port)
    );

    // Pads come straight from the mux; every mux input that reaches them is a flip-flop.
    assign pad = pad_c;

    assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
    assign s_axi_wready  = !st_q.w_got && !st_q.bvalid;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;

    always_comb begin
        logic [7:0] wb;
        wb   = 8'h00;
        st_d = st_q;
        // Peripheral requests are registered, but frozen in low power so
        // the pads keep the peripheral requests seen before entry; bdm_release and writes still act.
        if (!low_power) begin
            st_d.periph = periph; // [R17] [R18]
        end
        if (bdm_release) begin
            st_d.bdm_en = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.aw_got  = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.w_got  = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        if (st_q.aw_got && st_q.w_got) begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = pio_mapped(st_q.aw_addr) ? PIO_RESP_OKAY : PIO_RESP_SLVERR;
            // Only the low byte holds state, so only lane 0 matters.
            if (st_q.w_strb[0]) begin
                wb = st_q.w_data[7:0];
                unique case (st_q.aw_addr)
                    PIO_OFS_DATA:  st_d.cfg.data  = wb; // [R8] [R19]
                    PIO_OFS_DIR:   st_d.cfg.dir   = wb & ~PIO_OUT_ONLY_MASK; // [R6]
                    PIO_OFS_PULL:  st_d.cfg.pull  = wb; // [R16]
                    PIO_OFS_SLEW:  st_d.cfg.slew  = wb; // [R16]
                    PIO_OFS_DRIVE: st_d.cfg.drive = wb;
                    default:       st_d.cfg       = st_q.cfg;
                endcase
            end
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = pio_mapped(s_axi_araddr) ? PIO_RESP_OKAY : PIO_RESP_SLVERR;
            unique case (s_axi_araddr)
                PIO_OFS_DATA:   st_d.rdata = {24'h000000, rd_port}; // [R6] [R7] [R13]
                PIO_OFS_DIR:    st_d.rdata = {24'h000000, st_q.cfg.dir};
                PIO_OFS_PULL:   st_d.rdata = {24'h000000, st_q.cfg.pull};
                PIO_OFS_SLEW:   st_d.rdata = {24'h000000, st_q.cfg.slew};
                PIO_OFS_DRIVE:  st_d.rdata = {24'h000000, st_q.cfg.drive};
                PIO_OFS_PINLVL: st_d.rdata = {24'h000000, pin_in & pad_c.ibuf_en};
                PIO_OFS_ID:     st_d.rdata = PIO_ID_VALUE;
                default:        st_d.rdata = 32'h0000_0000;
            endcase
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q             <= '0;
            st_q.cfg.data    <= PIO_RST_DATA;  // [R9] [R19]
            st_q.cfg.dir     <= PIO_RST_DIR;   // [R4]
            st_q.cfg.pull    <= PIO_RST_PULL;  // [R4]
            st_q.cfg.slew    <= PIO_RST_SLEW;
            st_q.cfg.drive   <= PIO_RST_DRIVE; // [R5]
            st_q.periph      <= '0;            // [R3]
            st_q.bdm_en      <= 1'b1;          // [R4]
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// ===== src/pio_pkg.sv
/*
 * Package for the parallel I/O pin control block: register map, field layout,
 * reset values and the packed carriers shared by the top and the pin cell.
 * Assumes a 32-bit AXI4-Lite register bus clocked by aclk.
 */
package pio_pkg;

    localparam int unsigned PIO_NPINS = 8;
    localparam int unsigned PIO_AW    = 8;

    // Register byte offsets.
    localparam logic [7:0] PIO_OFS_DATA   = 8'h00;
    localparam logic [7:0] PIO_OFS_DIR    = 8'h04;
    localparam logic [7:0] PIO_OFS_PULL   = 8'h08;
    localparam logic [7:0] PIO_OFS_SLEW   = 8'h0C;
    localparam logic [7:0] PIO_OFS_DRIVE  = 8'h10;
    localparam logic [7:0] PIO_OFS_PINLVL = 8'h14;
    localparam logic [7:0] PIO_OFS_ID     = 8'h18;

    // Reset values.
    localparam logic [7:0] PIO_RST_DATA  = 8'h00;
    localparam logic [7:0] PIO_RST_DIR   = 8'h00;
    localparam logic [7:0] PIO_RST_PULL  = 8'h00;
    localparam logic [7:0] PIO_RST_SLEW  = 8'h00;
    localparam logic [7:0] PIO_RST_DRIVE = 8'h00;

    // Pin index of the output-only pin; it has no input buffer.
    localparam int unsigned PIO_OUT_ONLY_IDX = 4;
    localparam logic [7:0]  PIO_OUT_ONLY_MASK = 8'h10;

    // Block identity word; the value is arbitrary.
    localparam logic [31:0] PIO_ID_VALUE = 32'h0000_5A10;

    localparam logic [1:0] PIO_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PIO_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] pull;
        logic [7:0] slew;
        logic [7:0] drive;
    } pio_cfg_s;

    // Request from the on-chip peripherals that share the pins.
    typedef struct packed {
        logic [7:0] dig_en;
        logic [7:0] dig_out;
        logic [7:0] dig_oe;
        logic [7:0] ana_en;
    } pio_periph_s;

    // Pin pad controls; oe_n is low while the pad is driven.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
        logic [7:0] ibuf_en;
        logic [7:0] pull_en;
        logic [7:0] slew_en;
        logic [7:0] drive_hi;
    } pio_pad_s;

endpackage

// ===== src/pio_pin_cell.sv
/*
 * Pad multiplexer for the whole port: decides who drives each pad, whether
 * its input buffer is on, and what a data read returns.
 * Assumes the register state arrives already reset to safe values.
 */
`timescale 1ns/1ps
module pio_pin_cell (
    input  pio_pkg::pio_cfg_s    cfg,
    input  pio_pkg::pio_periph_s periph,
    input  logic [7:0]           pin_in,
    input  logic                 bdm_en,
    output pio_pkg::pio_pad_s    pad,
    output logic [7:0]           rd_data
);
    import pio_pkg::*;

    // Per-pin results are gathered on nets, so each pin owns its own bit.
    wire logic [7:0] out_v;
    wire logic [7:0] oe_n_v;
    wire logic [7:0] ibuf_v;
    wire logic [7:0] rd_v;

    genvar g;
    generate
        for (g = 0; g < PIO_NPINS; g++) begin : g_pin
            logic ana;
            logic dig;
            // Analog wins over digital when both are enabled.
            assign ana = periph.ana_en[g]; // [R14]
            assign dig = (periph.dig_en[g] && !ana) ||
                         (g == PIO_OUT_ONLY_IDX && bdm_en); // [R1] [R2] [R4]
            assign ibuf_v[g] = !ana && (g != PIO_OUT_ONLY_IDX); // [R10] [R12]
            // An analog pin is parked undriven at a low level.
            assign out_v[g]  = !ana && (dig ? periph.dig_out[g] : cfg.data[g]); // [R8] [R11]
            assign oe_n_v[g] = ana || (dig ? !periph.dig_oe[g] : !cfg.dir[g]); // [R6] [R7] [R12]
            // Direction picks the read source even under a digital function.
            assign rd_v[g] = cfg.dir[g] ? cfg.data[g] : (ibuf_v[g] && pin_in[g]); // [R7] [R11] [R13]
        end
    endgenerate

    assign rd_data = rd_v;
    assign pad     = '{out:      out_v,
                       oe_n:     oe_n_v,
                       ibuf_en:  ibuf_v,
                       pull_en:  cfg.pull,   // [R16]
                       slew_en:  cfg.slew,   // [R16]
                       drive_hi: cfg.drive};
endmodule

// ===== bench/pio_port_props.sv
/* Checker for the parallel I/O port: pad ownership, reset state and bus timing.
   Assumes it is bound to pio_port and sees only its ports. */
`timescale 1ns/1ps
module pio_port_props
    import pio_pkg::*;
(
    input logic                 aclk,
    input logic                 aresetn,
    input logic                 s_axi_awvalid,
    input logic                 s_axi_awready,
    input logic                 s_axi_wvalid,
    input logic                 s_axi_wready,
    input logic                 s_axi_bvalid,
    input logic                 s_axi_bready,
    input logic                 s_axi_arvalid,
    input logic                 s_axi_arready,
    input logic                 s_axi_rvalid,
    input pio_pkg::pio_periph_s periph,
    input logic                 bdm_release,
    input logic                 low_power,
    input pio_pkg::pio_pad_s    pad
);
    pio_periph_s per_q;
    logic        live_q;
    logic [7:0]  dm;
    // The design samples peripheral requests a cycle late, so the checker keeps its own copy.
    always_ff @(posedge aclk) begin
        per_q <= periph;
        live_q <= aresetn && !low_power;
    end
    assign dm = per_q.dig_en & ~per_q.ana_en & 8'hEF;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ana_off_a: assert property (live_q |-> (~pad.oe_n & per_q.ana_en & 8'hEF) == 8'h00)
        else $error("analog pin driven");
    ibuf_on_a: assert property (live_q |-> pad.ibuf_en == (~per_q.ana_en & 8'hEF))
        else $error("input buffer state wrong");
    dig_own_a: assert property (live_q |-> ((pad.oe_n ^ ~per_q.dig_oe) & dm) == 8'h00
        && ((pad.out ^ per_q.dig_out) & dm & per_q.dig_oe) == 8'h00)
        else $error("digital function does not own pin");
    rst_safe_a: assert property (disable iff (1'b0) !aresetn |=> pad.oe_n == 8'hFF
        && pad.pull_en == 8'h00 && pad.drive_hi == 8'h00)
        else $error("pins not safe after reset");
    lp_hold_a: assert property ($past(aresetn) && $past(low_power) && !$past(bdm_release)
        && !$rose(s_axi_bvalid) |-> $stable(pad))
        else $error("pad moved in low power");
    cfg_stable_a: assert property ($past(aresetn) && !$rose(s_axi_bvalid) |->
        $stable(pad.pull_en) && $stable(pad.slew_en) && $stable(pad.drive_hi))
        else $error("pin control changed without write");
    b_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    r_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
endmodule
bind pio_port pio_port_props u_props (.*);

// ===== bench/pio_pins_model.sv
/* Board model of the eight pads: a driven pad shows its output level.
   Assumes the bench supplies the level of every pad left floating. */
`timescale 1ns/1ps
module pio_pins_model
    import pio_pkg::*;
(
    input pio_pkg::pio_pad_s pad,
    input logic [7:0]        ext,
    output logic [7:0]       pin_in
);
    // A released pad takes ext at once, so it never keeps its old level.
    assign pin_in = (~pad.oe_n & pad.out) | (pad.oe_n & ext);
endmodule

// ===== bench/pio_port_tb_top.sv
/* Self-checking bench for pio_port with random pin and peripheral traffic.
   Assumes the pins model file and the checker are compiled alongside. */
`timescale 1ns/1ps
module pio_port_tb_top;
    import pio_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, low_power = 1'b0, bdm_release = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ext = 8'h00, pin_in;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h67252772;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    pio_periph_s periph = '0, pv;
    pio_pad_s    pad, sv;
    logic [7:0]  cf [5];
    logic [7:0]  dr, m1, m2, pl;
    int          n_checks = 0, failures = 0;
    pio_port dut (.*);
    pio_pins_model pins (.*);
    always #2 aclk = ~aclk;
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] exp_rd(logic [7:0] d, dir, an, pin);
        return (d & dir) | (pin & ~dir & ~an & ~PIO_OUT_ONLY_MASK);
    endfunction
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_ok, w_ok, b_ok;
        logic [1:0] r;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            b_ok = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end while (!b_ok);
        chk(48'(r), 48'(er));
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ar_ok, r_ok;
        logic [31:0] d;
        logic [1:0] r;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ar_ok = s_axi_arvalid && s_axi_arready;
            r_ok = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end while (!r_ok);
        chk({14'h0, r, d}, {14'h0, er, e});
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk(48'(pad.oe_n), 48'hFF);
        chk(48'(pad.pull_en | pad.drive_hi), 48'h0);
        @(posedge aclk);
        for (int i = 1; i < 5; i++) rc(8'(4 * i), 32'h0, PIO_RESP_OKAY);
        rc(8'h1C, 32'h0, PIO_RESP_SLVERR);
        rc(PIO_OFS_ID, PIO_ID_VALUE, PIO_RESP_OKAY);
        $display("reset and map test done");
        for (int k = 0; k < 40; k++) begin
            pv = rnd();
            // Analog lands on pins both with and without a digital function.
            pv.ana_en = pv.ana_en & pv.dig_out;
            periph <= pv;
            ext <= 8'(rnd());
            for (int j = 0; j < 5; j++) cf[j] = 8'(rnd());
            if (k == 20) begin
                bdm_release <= 1'b1;
                @(posedge aclk);
                bdm_release <= 1'b0;
            end
            // Data goes ahead of direction so a new output never shows a stale level.
            for (int j = 0; j < 5; j++) wr(8'(4 * j), cf[j], PIO_RESP_OKAY);
            dr = cf[1] & 8'hEF;
            m1 = dr & ~pv.dig_en & ~pv.ana_en & 8'hEF;
            m2 = pv.dig_en & pv.dig_oe & ~pv.ana_en & 8'hEF;
            // Pin levels as the board sees them: driven pads, else the outside level.
            pl = (cf[0] & m1) | (pv.dig_out & m2) | (ext & ~(m1 | m2));
            @(negedge aclk);
            chk(48'(pad.oe_n | 8'h10), {40'h0, ~(m1 | m2)});
            chk(48'(pad.out & (m1 | m2)), 48'((cf[0] & m1) | (pv.dig_out & m2)));
            chk(48'(pad.ibuf_en), {40'h0, ~pv.ana_en & 8'hEF});
            chk(48'({pad.pull_en, pad.slew_en, pad.drive_hi}),
                {24'h0, cf[2], cf[3], cf[4]});
            @(posedge aclk);
            rc(PIO_OFS_DIR, 32'(dr), PIO_RESP_OKAY);
            rc(PIO_OFS_DATA, 32'(exp_rd(cf[0], dr, pv.ana_en, pl)), PIO_RESP_OKAY);
            rc(PIO_OFS_PINLVL, 32'(pl & ~pv.ana_en & 8'hEF), PIO_RESP_OKAY);
        end
        // A write with lane 0 off must leave the register alone.
        s_axi_wstrb <= 4'h0;
        wr(PIO_OFS_DIR, ~dr, PIO_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        wr(8'h1C, 8'hFF, PIO_RESP_SLVERR);
        rc(PIO_OFS_DIR, 32'(dr), PIO_RESP_OKAY);
        $display("random pin test done");
        @(negedge aclk);
        sv = pad;
        @(posedge aclk);
        low_power <= 1'b1;
        periph <= ~pv;
        repeat (4) @(negedge aclk);
        chk(pad, sv);
        @(posedge aclk);
        periph <= pv;
        repeat (2) @(posedge aclk);
        low_power <= 1'b0;
        repeat (3) @(negedge aclk);
        chk(pad, sv);
        $display("low power test done");
        close_out();
    end
    initial begin
        repeat (6000) @(posedge aclk);
        failures++;
        close_out();
    end
endmodule
